/* File: status_flags_pkg.sv */
package status_flags_pkg;

    // register offsets on the plain register port
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_STATUS = 3'h0;
    localparam logic [2:0] OFF_CORE_CTRL = 3'h1;
    localparam logic [2:0] OFF_INT_CTRL1 = 3'h2;
    localparam logic [2:0] OFF_EVT_STATUS = 3'h3;
    localparam logic [2:0] OFF_EVT_MASK = 3'h4;

    // cpu_status_word field positions
    localparam int BIT_OVF_A = 15;
    localparam int BIT_OVF_B = 14;
    localparam int BIT_SAT_A = 13;
    localparam int BIT_SAT_B = 12;
    localparam int BIT_ANY_OVF = 11;
    localparam int BIT_ANY_SAT = 10;
    localparam int BIT_LOOP = 9;
    localparam int BIT_HALF_CARRY = 8;
    localparam int BIT_IPL_HI = 7;
    localparam int BIT_IPL_LO = 5;
    localparam int BIT_REPEAT = 4;
    localparam int BIT_NEG = 3;
    localparam int BIT_OVF = 2;
    localparam int BIT_ZERO = 1;
    localparam int BIT_CARRY = 0;

    // fourth priority bit and nesting switch positions
    localparam int BIT_IPL3 = 3;
    localparam int BIT_NEST_OFF = 15;

    // event status and mask layout
    localparam int EVT_W = 4;
    localparam int EVT_OVF_A = 0;
    localparam int EVT_OVF_B = 1;
    localparam int EVT_SAT_A = 2;
    localparam int EVT_SAT_B = 3;

    // values after reset
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // priority field value that locks out user interrupts
    localparam logic [2:0] IPL_TOP = 3'h7;

endpackage

/* File: alu_flag_eval.sv */
`timescale 1ns/1ps

module alu_flag_eval (
    // operands and operation
    input wire logic [15:0] op_a_in,
    input wire logic [15:0] op_b_in,
    input wire logic sub_in,
    input wire logic carry_in,
    input wire logic byte_in,
    // evaluated flags
    output logic neg_out,
    output logic ovf_out,
    output logic zero_out,
    output logic carry_out,
    output logic half_carry_out
);

    // picks the sign position for byte or word width
    function automatic logic sign_of(input logic [15:0] v, input logic is_byte);
        sign_of = is_byte ? v[7] : v[15];
    endfunction

    logic [15:0] b_eff;
    logic [16:0] sum_word;
    logic [8:0] sum_low;
    logic [4:0] sum_nib;
    logic [15:0] result;
    logic sa;
    logic sb;
    logic sr;

    // subtract as a plus inverted b; carry_in is 1 for a plain subtract
    assign b_eff = sub_in ? ~op_b_in : op_b_in;
    assign sum_word = {1'b0, op_a_in} + {1'b0, b_eff} + {16'h0000, carry_in};
    assign sum_low = {1'b0, op_a_in[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, carry_in};
    assign sum_nib = {1'b0, op_a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
    assign result = sum_word[15:0];

    // signs of both operands and result at the active width
    assign sa = sign_of(op_a_in, byte_in);
    assign sb = sign_of(b_eff, byte_in);
    assign sr = sign_of(result, byte_in);

    // flags for the selected width
    assign neg_out = sr;
    assign ovf_out = (sa == sb) && (sr != sa);
    assign zero_out = byte_in ? (result[7:0] == 8'h00) : (result == 16'h0000);
    assign carry_out = byte_in ? sum_low[8] : sum_word[16];
    assign half_carry_out = byte_in ? sum_nib[4] : sum_low[8];

endmodule

/* File: cpu_status_flags.sv */
`timescale 1ns/1ps

module cpu_status_flags (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [status_flags_pkg::ADDR_W-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // alu flag update
    input wire logic alu_valid_in,
    input wire logic [15:0] op_a_in,
    input wire logic [15:0] op_b_in,
    input wire logic alu_sub_in,
    input wire logic alu_carry_in,
    input wire logic alu_byte_in,
    // accumulator update
    input wire logic acc_valid_in,
    input wire logic acc_a_overflow_in,
    input wire logic acc_b_overflow_in,
    input wire logic acc_a_clip_in,
    input wire logic acc_b_clip_in,
    // loop state from the sequencer
    input wire logic loop_block_active_in,
    input wire logic repeat_active_in,
    // status and priority
    output logic [15:0] cpu_status_word_out,
    output logic [3:0] cpu_priority_level_out,
    output logic user_irq_off_out,
    output logic irq_out
);

    logic [15:0] sw_reg;
    logic [15:0] sw_next;
    logic ipl3_reg;
    logic ipl3_next;
    logic nesting_off_reg;
    logic nesting_off_next;
    logic [3:0] evt_reg;
    logic [3:0] evt_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;
    logic [3:0] evt_set;
    logic [3:0] level_reg;
    logic [3:0] level_next;
    logic off_reg;
    logic irq_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rd_mux;
    logic f_neg;
    logic f_ovf;
    logic f_zero;
    logic f_carry;
    logic f_half;

    // address decode
    wire sw_wr = wr_in && (addr_in == status_flags_pkg::OFF_STATUS);
    wire cc_wr = wr_in && (addr_in == status_flags_pkg::OFF_CORE_CTRL);
    wire ic_wr = wr_in && (addr_in == status_flags_pkg::OFF_INT_CTRL1);
    wire ev_wr = wr_in && (addr_in == status_flags_pkg::OFF_EVT_STATUS);
    wire mk_wr = wr_in && (addr_in == status_flags_pkg::OFF_EVT_MASK);

    // flag evaluation for the current alu operation
    alu_flag_eval i_alu_flag_eval (
        .op_a_in(op_a_in),
        .op_b_in(op_b_in),
        .sub_in(alu_sub_in),
        .carry_in(alu_carry_in),
        .byte_in(alu_byte_in),
        .neg_out(f_neg),
        .ovf_out(f_ovf),
        .zero_out(f_zero),
        .carry_out(f_carry),
        .half_carry_out(f_half)
    );

    // software clear of a combined flag clears both accumulator flags under it
    wire keep_ovf = wdata_in[status_flags_pkg::BIT_ANY_OVF];
    wire keep_sat = wdata_in[status_flags_pkg::BIT_ANY_SAT];
    wire ipl_wr = sw_wr && !nesting_off_reg;

    // accumulator overflow follows each accumulator operation
    wire oa_n = acc_valid_in ? acc_a_overflow_in :
        sw_wr ? (wdata_in[status_flags_pkg::BIT_OVF_A] & keep_ovf) :
        sw_reg[status_flags_pkg::BIT_OVF_A];
    wire ob_n = acc_valid_in ? acc_b_overflow_in :
        sw_wr ? (wdata_in[status_flags_pkg::BIT_OVF_B] & keep_ovf) :
        sw_reg[status_flags_pkg::BIT_OVF_B];

    // hardware clip sets win over a software write in the same cycle
    wire sa_set = acc_valid_in && acc_a_clip_in;
    wire sb_set = acc_valid_in && acc_b_clip_in;
    wire sa_n = sa_set || (sw_wr ? (wdata_in[status_flags_pkg::BIT_SAT_A] & keep_sat) :
        sw_reg[status_flags_pkg::BIT_SAT_A]);
    wire sb_n = sb_set || (sw_wr ? (wdata_in[status_flags_pkg::BIT_SAT_B] & keep_sat) :
        sw_reg[status_flags_pkg::BIT_SAT_B]);

    // alu flags: the datapath wins over a software write in the same cycle
    wire [4:0] alu_flags = {f_half, f_neg, f_ovf, f_zero, f_carry};
    wire [4:0] sw_flags = {sw_reg[status_flags_pkg::BIT_HALF_CARRY], sw_reg[3:0]};
    wire [4:0] wr_flags = {wdata_in[status_flags_pkg::BIT_HALF_CARRY], wdata_in[3:0]};
    wire [4:0] flags_n = alu_valid_in ? alu_flags : (sw_wr ? wr_flags : sw_flags);
    wire [2:0] ipl_n = ipl_wr ? wdata_in[7:5] : sw_reg[7:5];

    // next status word; combined bits are always the OR of their parts
    assign sw_next = {oa_n, ob_n, sa_n, sb_n,
        oa_n | ob_n, sa_n | sb_n,
        loop_block_active_in, flags_n[4],
        ipl_n, repeat_active_in,
        flags_n[3:0]};

    // control bits held here for the priority logic
    assign ipl3_next = cc_wr ? wdata_in[status_flags_pkg::BIT_IPL3] : ipl3_reg;
    assign nesting_off_next = ic_wr ? wdata_in[status_flags_pkg::BIT_NEST_OFF] :
        nesting_off_reg;
    assign level_next = {ipl3_next, sw_next[7:5]};

    // events set sticky bits; a set in the clearing cycle survives
    assign evt_set[status_flags_pkg::EVT_OVF_A] = acc_valid_in && acc_a_overflow_in;
    assign evt_set[status_flags_pkg::EVT_OVF_B] = acc_valid_in && acc_b_overflow_in;
    assign evt_set[status_flags_pkg::EVT_SAT_A] = sa_set;
    assign evt_set[status_flags_pkg::EVT_SAT_B] = sb_set;
    assign evt_next = (evt_reg & ~(ev_wr ? wdata_in[3:0] : 4'h0)) | evt_set;
    assign mask_next = mk_wr ? wdata_in[3:0] : mask_reg;

    // read mux; unmapped offsets read zero
    assign rd_mux = (addr_in == status_flags_pkg::OFF_STATUS) ? sw_reg :
        (addr_in == status_flags_pkg::OFF_CORE_CTRL) ? {12'h000, ipl3_reg, 3'h0} :
        (addr_in == status_flags_pkg::OFF_INT_CTRL1) ? {nesting_off_reg, 15'h0000} :
        (addr_in == status_flags_pkg::OFF_EVT_STATUS) ? {12'h000, evt_reg} :
        (addr_in == status_flags_pkg::OFF_EVT_MASK) ? {12'h000, mask_reg} : 16'h0000;

    // output flop inputs; user interrupts are off at level seven and above
    wire off_next = level_next[3] ||
        (level_next[2:0] == status_flags_pkg::IPL_TOP);
    wire irq_next = |(evt_next & mask_next);
    wire [15:0] rdata_next = rd_in ? rd_mux : 16'h0000;

    // state registers
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sw_reg <= status_flags_pkg::STATUS_RESET;
            ipl3_reg <= 1'b0;
            nesting_off_reg <= 1'b0;
            evt_reg <= status_flags_pkg::EVT_RESET;
            mask_reg <= status_flags_pkg::EVT_RESET;
        end
        else
        begin
            sw_reg <= sw_next;
            ipl3_reg <= ipl3_next;
            nesting_off_reg <= nesting_off_next;
            evt_reg <= evt_next;
            mask_reg <= mask_next;
        end
    end

    // priority outputs, computed from next state so they track the state registers
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            level_reg <= status_flags_pkg::LEVEL_RESET;
            off_reg <= 1'b0;
        end
        else
        begin
            level_reg <= level_next;
            off_reg <= off_next;
        end
    end

    // interrupt pin from a flop, so decode glitches never reach it
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_reg <= 1'b0;
        else
            irq_reg <= irq_next;
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rdata_reg <= status_flags_pkg::RDATA_RESET;
        else
            rdata_reg <= rdata_next;
    end

    assign cpu_status_word_out = sw_reg;
    assign cpu_priority_level_out = level_reg;
    assign user_irq_off_out = off_reg;
    assign irq_out = irq_reg;
    assign rdata_out = rdata_reg;

    // checks
    default clocking dcb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    AST_CLIP_CLEAR: assert property (
        sw_wr && !wdata_in[status_flags_pkg::BIT_ANY_SAT] && !acc_valid_in
        |=> !sw_reg[13] && !sw_reg[12] && !sw_reg[10])
        else $error("combined clip clear did not clear both sticky flags");
    AST_CLIP_STICKY: assert property (
        acc_valid_in && acc_a_clip_in |=> sw_reg[13] && sw_reg[10])
        else $error("clip event lost");
    AST_LEVEL: assert property (
        cpu_priority_level_out == {ipl3_reg, sw_reg[7:5]})
        else $error("priority level not formed from both parts");
    AST_TOP_BIT_OFF: assert property (
        cpu_priority_level_out[3] |-> user_irq_off_out)
        else $error("user interrupts not off with fourth bit set");
    AST_LEVEL_SEVEN: assert property (
        !cpu_priority_level_out[3] |->
        (user_irq_off_out == (cpu_priority_level_out[2:0] == 3'h7)))
        else $error("level seven decode wrong");
    AST_NEST_LOCK: assert property (
        sw_wr && nesting_off_reg |=> $stable(sw_reg[7:5]))
        else $error("priority field changed while locked");
    AST_REPEAT: assert property (
        ##1 sw_reg[4] == $past(repeat_active_in))
        else $error("repeat bit does not follow loop");
    AST_NEG: assert property (
        alu_valid_in && !alu_byte_in && !alu_sub_in && !alu_carry_in
        && op_b_in == 16'h0000 |=> sw_reg[3] == $past(op_a_in[15]))
        else $error("negative flag wrong");
    AST_OVF: assert property (
        alu_valid_in && !alu_byte_in && !alu_sub_in && !alu_carry_in
        && op_a_in == 16'h7FFF && op_b_in == 16'h0001 |=> sw_reg[2] && sw_reg[3])
        else $error("signed overflow not flagged");
    AST_ZERO_CARRY: assert property (
        alu_valid_in && !alu_byte_in && !alu_sub_in && !alu_carry_in
        && op_a_in == 16'hFFFF && op_b_in == 16'h0001 |=> sw_reg[1] && sw_reg[0])
        else $error("zero or carry flag wrong");
    AST_HALF: assert property (
        alu_valid_in && alu_byte_in && !alu_sub_in && !alu_carry_in
        && op_a_in == 16'h000F && op_b_in == 16'h0001 |=> sw_reg[8] && !sw_reg[0])
        else $error("half carry wrong");
    AST_COMBINED: assert property (
        sw_reg[11] == (sw_reg[15] | sw_reg[14]) && sw_reg[10] == (sw_reg[13] | sw_reg[12]))
        else $error("combined flags not the OR");

    // accumulator and register port checks
    AST_OVF_CLEAR: assert property (
        sw_wr && !wdata_in[status_flags_pkg::BIT_ANY_OVF] && !acc_valid_in
        |=> !sw_reg[15] && !sw_reg[14] && !sw_reg[11])
        else $error("combined overflow clear did not clear both flags");
    AST_ACC_OVF: assert property (
        acc_valid_in |=> sw_reg[15] == $past(acc_a_overflow_in)
        && sw_reg[14] == $past(acc_b_overflow_in))
        else $error("accumulator overflow flags do not follow the operation");
    AST_CLIP_STICKY_B: assert property (
        acc_valid_in && acc_b_clip_in |=> sw_reg[12] && sw_reg[10])
        else $error("clip event on accumulator b lost");
    AST_IRQ: assert property (
        irq_out == |(evt_reg & mask_reg))
        else $error("interrupt output does not match unmasked events");
    AST_RDATA_IDLE: assert property (
        !rd_in |=> rdata_out == 16'h0000)
        else $error("read data not zero outside a read");
    AST_RDATA_STATUS: assert property (
        rd_in && addr_in == status_flags_pkg::OFF_STATUS |=> rdata_out == $past(sw_reg))
        else $error("status read returned the wrong word");

    // priority field checks
    AST_NEST_FREE: assert property (
        sw_wr && !nesting_off_reg |=> sw_reg[7:5] == $past(wdata_in[7:5]))
        else $error("priority field write lost while unlocked");
    AST_LEVEL_TOP: assert property (
        cc_wr |=> cpu_priority_level_out[3] == $past(wdata_in[status_flags_pkg::BIT_IPL3]))
        else $error("fourth priority bit not taken from core control");

    // fixed alu cases
    AST_HALF_WORD: assert property (
        alu_valid_in && !alu_byte_in && !alu_sub_in && !alu_carry_in
        && op_a_in == 16'h7FFF && op_b_in == 16'h0001 |=> sw_reg[8] && !sw_reg[0])
        else $error("word half carry wrong");
    AST_SUB_CARRY: assert property (
        alu_valid_in && !alu_byte_in && alu_sub_in && alu_carry_in
        && op_a_in == 16'h0005 && op_b_in == 16'h0003 |=> sw_reg[0] && !sw_reg[1] && !sw_reg[3])
        else $error("carry on subtract without borrow wrong");
    AST_ZERO_CLEAR: assert property (
        alu_valid_in && !alu_byte_in && !alu_sub_in && !alu_carry_in
        && op_a_in == 16'h0001 && op_b_in == 16'h0001 |=> !sw_reg[1] && !sw_reg[2])
        else $error("zero flag not cleared on a non-zero result");

    CVR_CLIP_CLEAR: cover property (sw_reg[10] ##1 sw_wr ##1 !sw_reg[10]);
    CVR_LOCKED_WRITE: cover property (sw_wr && nesting_off_reg);
    CVR_IRQ: cover property (!irq_out ##1 irq_out);
    CVR_SIGNED_OVF: cover property (alu_valid_in ##1 sw_reg[2]);
    CVR_USER_OFF: cover property (!user_irq_off_out ##1 user_irq_off_out);

endmodule

/* File: tb_cpu_status_flags.sv */
`timescale 1ns/1ps

module tb_cpu_status_flags;
    // clock, reset and stimulus
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [status_flags_pkg::ADDR_W-1:0] addr_in = '0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic alu_valid_in = 1'b0;
    logic [15:0] op_a_in = 16'h0000;
    logic [15:0] op_b_in = 16'h0000;
    logic alu_sub_in = 1'b0;
    logic alu_carry_in = 1'b0;
    logic alu_byte_in = 1'b0;
    logic acc_valid_in = 1'b0;
    logic acc_a_overflow_in = 1'b0;
    logic acc_b_overflow_in = 1'b0;
    logic acc_a_clip_in = 1'b0;
    logic acc_b_clip_in = 1'b0;
    logic loop_block_active_in = 1'b0;
    logic repeat_active_in = 1'b0;
    // observed outputs
    logic [15:0] rdata_out;
    logic [15:0] cpu_status_word_out;
    logic [3:0] cpu_priority_level_out;
    logic user_irq_off_out;
    logic irq_out;
    logic [15:0] rv;
    int errors = 0;
    int samples_checked = 0;

    // 10 MHz core clock
    always #50 clk_in = ~clk_in;

    cpu_status_flags i_cpu_status_flags (
        .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .alu_valid_in(alu_valid_in),
        .op_a_in(op_a_in), .op_b_in(op_b_in), .alu_sub_in(alu_sub_in),
        .alu_carry_in(alu_carry_in), .alu_byte_in(alu_byte_in), .acc_valid_in(acc_valid_in),
        .acc_a_overflow_in(acc_a_overflow_in), .acc_b_overflow_in(acc_b_overflow_in),
        .acc_a_clip_in(acc_a_clip_in), .acc_b_clip_in(acc_b_clip_in),
        .loop_block_active_in(loop_block_active_in), .repeat_active_in(repeat_active_in),
        .cpu_status_word_out(cpu_status_word_out),
        .cpu_priority_level_out(cpu_priority_level_out),
        .user_irq_off_out(user_irq_off_out), .irq_out(irq_out)
    );

    // one compare, counted either way
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t ns: seen %04h expected %04h", $time, seen, exp);
        end
    endtask

    // extra edge so registered results derived from registered state have landed
    task automatic settle;
        @(posedge clk_in);
        #1;
    endtask

    // register port cycles
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        settle();
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    // one alu flag update
    task automatic alu(input logic [15:0] a, b, input logic s, c, y);
        @(posedge clk_in);
        op_a_in <= a;
        op_b_in <= b;
        alu_sub_in <= s;
        alu_carry_in <= c;
        alu_byte_in <= y;
        alu_valid_in <= 1'b1;
        @(posedge clk_in);
        alu_valid_in <= 1'b0;
        settle();
    endtask

    // one accumulator update
    task automatic acc(input logic oa, ob, sa, sb);
        @(posedge clk_in);
        acc_a_overflow_in <= oa;
        acc_b_overflow_in <= ob;
        acc_a_clip_in <= sa;
        acc_b_clip_in <= sb;
        acc_valid_in <= 1'b1;
        @(posedge clk_in);
        acc_valid_in <= 1'b0;
        settle();
    endtask

    task automatic t_alu;
        alu(16'h7FFF, 16'h0001, 1'b0, 1'b0, 1'b0);
        chk(cpu_status_word_out, 16'h010C);
        alu(16'h12FF, 16'h0001, 1'b0, 1'b0, 1'b1);
        chk(cpu_status_word_out, 16'h0103);
        alu(16'h0005, 16'h0003, 1'b1, 1'b1, 1'b0);
        chk(cpu_status_word_out, 16'h0101);
        alu(16'hFFFF, 16'h0001, 1'b0, 1'b0, 1'b0);
        chk(cpu_status_word_out, 16'h0103);
        alu(16'h000F, 16'h0001, 1'b0, 1'b0, 1'b1);
        chk(cpu_status_word_out, 16'h0100);
        alu(16'h8000, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk(cpu_status_word_out, 16'h0008);
        alu(16'h0001, 16'h0001, 1'b0, 1'b0, 1'b0);
        chk(cpu_status_word_out, 16'h0000);
        $display("test alu flags done");
    endtask

    task automatic t_acc;
        acc(1'b1, 1'b0, 1'b0, 1'b1);
        chk(cpu_status_word_out, 16'h9C00);
        acc(1'b0, 1'b0, 1'b0, 1'b0);
        chk(cpu_status_word_out, 16'h1400);
        rd(status_flags_pkg::OFF_EVT_STATUS, rv);
        chk(rv, 16'h0009);
        chk({15'h0000, irq_out}, 16'h0000);
        wr(status_flags_pkg::OFF_EVT_MASK, 16'h0008);
        chk({15'h0000, irq_out}, 16'h0001);
        wr(status_flags_pkg::OFF_EVT_STATUS, 16'h0008);
        chk({15'h0000, irq_out}, 16'h0000);
        rd(status_flags_pkg::OFF_EVT_STATUS, rv);
        chk(rv, 16'h0001);
        $display("test accumulator flags done");
    endtask

    task automatic t_sticky;
        acc(1'b1, 1'b1, 1'b0, 1'b0);
        chk(cpu_status_word_out, 16'hDC00);
        wr(status_flags_pkg::OFF_STATUS, 16'hC000);
        chk(cpu_status_word_out, 16'h0000);
        wr(status_flags_pkg::OFF_STATUS, 16'h3400);
        rd(status_flags_pkg::OFF_STATUS, rv);
        chk(rv, 16'h3400);
        wr(status_flags_pkg::OFF_STATUS, 16'h3000);
        chk(cpu_status_word_out, 16'h0000);
        rd(3'h7, rv);
        chk(rv, 16'h0000);
        $display("test sticky clear done");
    endtask

    // every field value with the fourth bit clear and set
    task automatic t_ipl;
        for (int i = 0; i < 16; i++)
        begin
            wr(status_flags_pkg::OFF_CORE_CTRL, {12'h000, i[3], 3'h0});
            wr(status_flags_pkg::OFF_STATUS, {8'h00, i[2:0], 5'h00});
            chk({12'h000, cpu_priority_level_out}, 16'(i));
            chk({15'h0000, user_irq_off_out}, {15'h0000, i >= 7});
        end
        wr(status_flags_pkg::OFF_CORE_CTRL, 16'h0000);
        wr(status_flags_pkg::OFF_INT_CTRL1, 16'h8000);
        wr(status_flags_pkg::OFF_STATUS, 16'h0040);
        chk({12'h000, cpu_priority_level_out}, 16'h0007);
        rd(status_flags_pkg::OFF_INT_CTRL1, rv);
        chk(rv, 16'h8000);
        wr(status_flags_pkg::OFF_INT_CTRL1, 16'h0000);
        wr(status_flags_pkg::OFF_STATUS, 16'h0040);
        chk({12'h000, cpu_priority_level_out}, 16'h0002);
        $display("test priority level done");
    endtask

    task automatic t_loop;
        @(posedge clk_in);
        repeat_active_in <= 1'b1;
        loop_block_active_in <= 1'b1;
        wr(status_flags_pkg::OFF_STATUS, 16'h0000);
        chk(cpu_status_word_out & 16'h0210, 16'h0210);
        @(posedge clk_in);
        repeat_active_in <= 1'b0;
        loop_block_active_in <= 1'b0;
        wr(status_flags_pkg::OFF_STATUS, 16'h0210);
        chk(cpu_status_word_out & 16'h0210, 16'h0000);
        $display("test loop bits done");
    endtask

    // verdict and end of run
    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // guard against a hung sequence
    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        $display("Error at %0t ns: seen %04h expected %04h", $time, 16'h0000, 16'h0001);
        results();
    end

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        settle();
        chk(cpu_status_word_out, status_flags_pkg::STATUS_RESET);
        chk({11'h000, irq_out, cpu_priority_level_out}, 16'h0000);
        $display("test reset done");
        t_alu();
        t_acc();
        t_sticky();
        t_ipl();
        t_loop();
        results();
    end
endmodule
